// ==== src/scuc_ctrl.sv ====
// Smart card half-duplex character engine with its control and status registers.
// Assumes a synchronous register port and an open-drain card line joined outside.
`timescale 1ns/1ps
`default_nettype none
module scuc_ctrl
    import scuc_pkg::*;
#(
    parameter int ETU = ETU_CYCLES
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rstn,
    // Register port
    input  wire logic [31:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Card line, open drain
    input  wire logic        line_in,
    output logic             line_out,
    output logic             line_oe,
    // Interrupt
    output logic             irq
);
    scuc_regs_t          q;
    scuc_regs_t          d;
    logic [IRQ_W-1:0]    irq_set;
    logic [IRQ_W-1:0]    irq_clr;
    logic                tx_finish;
    logic                restart;
    logic [8:0]          guard_rem;

    scuc_etu_if etu ();

    scuc_etu_timer #(
        .ETU (ETU)
    ) u_timer (
        .core_clk (core_clk),
        .rstn     (rstn),
        .etu      (etu)
    );

    assign etu.restart = restart;

    // ------------------------------------------------------------------
    // Guard units left after the acknowledge window
    // ------------------------------------------------------------------
    always_comb begin
        if (q.prot) begin
            guard_rem = GUARD_NOMINAL;
        end else if (q.guard == GUARD_SINGLE) begin
            guard_rem = '0;
        end else begin
            guard_rem = GUARD_NOMINAL + {1'b0, q.guard};
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        d         = q;
        irq_set   = '0;
        irq_clr   = '0;
        tx_finish = 1'b0;
        restart   = 1'b0;
        d.rdata   = '0;

        case (q.st)
            ST_IDLE: begin
                d.drive = 1'b0;
                if (q.en && q.tx_pend && !q.locked) begin
                    d.shift = {^q.tx_hold, q.tx_hold, 1'b0};
                    d.bitn  = '0;
                    d.drive = 1'b1;
                    d.st    = ST_TX_BIT;
                    restart = 1'b1;
                end else if (q.en && !line_in) begin
                    d.bitn  = '0;
                    d.st    = ST_RX_BIT;
                    restart = 1'b1;
                end
            end
            ST_TX_BIT: begin
                d.drive = ~q.shift[0];
                if (etu.etu_tick) begin
                    d.shift = {1'b1, q.shift[9:1]};
                    if (q.bitn == LAST_BIT) begin
                        d.drive     = 1'b0;
                        d.nack_seen = 1'b0;
                        d.st        = ST_TX_NACK;
                    end else begin
                        d.bitn  = q.bitn + 4'h1;
                        d.drive = ~q.shift[1];
                    end
                end
            end
            ST_TX_NACK: begin
                // The card pulls the line low in this unit to refuse a T=0 character.
                if (etu.mid_tick && !q.prot && !line_in) begin
                    d.nack_seen = 1'b1;
                end
                if (etu.etu_tick) begin
                    d.gcnt = guard_rem;
                    if (guard_rem == 9'h000) begin
                        tx_finish = 1'b1;
                    end else begin
                        d.st = ST_TX_GRD;
                    end
                end
            end
            ST_TX_GRD: begin
                if (etu.etu_tick) begin
                    d.gcnt = q.gcnt - 9'h001;
                    if (q.gcnt == 9'h001) begin
                        tx_finish = 1'b1;
                    end
                end
            end
            ST_RX_BIT: begin
                if (etu.mid_tick) begin
                    if (q.bitn == 4'h0) begin
                        if (line_in) begin
                            d.st = ST_IDLE;
                        end
                    end else begin
                        d.rx_shift = {line_in, q.rx_shift[8:1]};
                    end
                end
                if (etu.etu_tick) begin
                    if (q.bitn == LAST_BIT) begin
                        d.st = ST_RX_SIG;
                    end else begin
                        d.bitn = q.bitn + 4'h1;
                    end
                end
            end
            ST_RX_SIG: begin
                if (etu.mid_tick) begin
                    d.rx_data               = q.rx_shift[7:0];
                    irq_set[IRQ_RX_DONE]    = 1'b1;
                    irq_set[IRQ_RX_PERR]    = ^q.rx_shift;
                    if (^q.rx_shift && !q.prot && !q.neg_ack_disable) begin
                        d.drive = 1'b1;
                        d.st    = ST_RX_NACK;
                    end else begin
                        d.st = ST_IDLE;
                    end
                end
            end
            ST_RX_NACK: begin
                if (etu.mid_tick) begin
                    d.drive = 1'b0;
                    d.st    = ST_IDLE;
                end
            end
            default: begin
                d.st    = ST_IDLE;
                d.drive = 1'b0;
            end
        endcase

        // The held character is kept until it is accepted, so a retry resends it from idle.
        if (tx_finish) begin
            d.st = ST_IDLE;
            if (q.nack_seen) begin
                if (q.tries == q.retry) begin
                    d.locked            = 1'b1;
                    d.tries             = '0;
                    irq_set[IRQ_TX_ERR] = 1'b1;
                end else begin
                    d.tries = q.tries + 3'h1;
                end
            end else begin
                d.tx_pend            = 1'b0;
                d.tries              = '0;
                irq_set[IRQ_TX_DONE] = 1'b1;
            end
        end

        // ------------------------------------------------------------------
        // Register writes
        // ------------------------------------------------------------------
        if (reg_wr) begin
            if (reg_addr == ADDR_CTRL) begin
                d.en      = reg_wdata[CTRL_EN_BIT];
                d.neg_ack_disable = reg_wdata[CTRL_NACK_BIT];
                d.prot    = reg_wdata[CTRL_PROT_BIT];
                d.retry   = reg_wdata[CTRL_RETRY_LSB +: 3];
                d.guard   = reg_wdata[CTRL_GUARD_LSB +: 8];
            end else if (reg_addr == ADDR_HALF_DUPLEX) begin
                d.half_duplex_enable = reg_wdata[0];
            end else if (reg_addr == ADDR_FLUSH) begin
                if (reg_wdata[FLUSH_BIT]) begin
                    d.tx_pend = 1'b0;
                    d.locked  = 1'b0;
                    d.tries   = '0;
                    if (q.st == ST_TX_BIT || q.st == ST_TX_NACK || q.st == ST_TX_GRD) begin
                        d.st    = ST_IDLE;
                        d.drive = 1'b0;
                    end
                end
            end else if (reg_addr == ADDR_TX_DATA) begin
                // A character is refused while the engine is off, locked or still holding one.
                if (q.en && !q.locked && !q.tx_pend) begin
                    d.tx_hold = reg_wdata[7:0];
                    d.tx_pend = 1'b1;
                end
            end else if (reg_addr == ADDR_IRQ_STAT) begin
                irq_clr = reg_wdata[IRQ_W-1:0];
            end else if (reg_addr == ADDR_IRQ_MASK) begin
                d.irq_mask = reg_wdata[IRQ_W-1:0];
            end
        end

        // Turning the engine off abandons any character in flight, leaving a pending one held for resending, and frees the line.
        if (!d.en) begin
            d.st    = ST_IDLE;
            d.drive = 1'b0;
        end

        // A hardware event in the same cycle as its clear keeps the flag set.
        d.irq_stat = (q.irq_stat & ~irq_clr) | irq_set;

        // ------------------------------------------------------------------
        // Register reads
        // ------------------------------------------------------------------
        if (reg_rd) begin
            if (reg_addr == ADDR_CTRL) begin
                d.rdata = {16'h0000, q.guard, q.retry, 2'b00, q.prot, q.neg_ack_disable, q.en};
            end else if (reg_addr == ADDR_HALF_DUPLEX) begin
                d.rdata = {31'h0000_0000, q.half_duplex_enable};
            end else if (reg_addr == ADDR_LINE_STAT) begin
                d.rdata = {28'h000_0000, q.tx_pend, q.st[2], q.st != ST_IDLE && !q.st[2], q.locked};
            end else if (reg_addr == ADDR_RX_DATA) begin
                d.rdata = {24'h00_0000, q.rx_data};
            end else if (reg_addr == ADDR_IRQ_STAT) begin
                d.rdata = {28'h000_0000, q.irq_stat};
            end else if (reg_addr == ADDR_IRQ_MASK) begin
                d.rdata = {28'h000_0000, q.irq_mask};
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            q          <= '0;
            q.st       <= ST_IDLE;
            q.en       <= CTRL_FLAG_RST;
            q.neg_ack_disable  <= CTRL_FLAG_RST;
            q.prot     <= CTRL_FLAG_RST;
            q.retry    <= RETRY_RST;
            q.guard    <= GUARD_RST;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata = q.rdata;
    assign line_out  = 1'b0;
    assign line_oe   = q.drive;
    assign irq       = |(q.irq_stat & q.irq_mask);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_reset_clears_ctrl: assert property (@(posedge core_clk)
        !rstn |=> !rstn || (!q.en && !q.neg_ack_disable && !q.prot))
        else $error("control flags not cleared by reset");

    a_disabled_line_free: assert property (@(posedge core_clk) disable iff (!rstn)
        !q.en && !reg_wr |=> !line_oe && q.st == ST_IDLE)
        else $error("line driven while disabled");

    a_tx_start_low: assert property (@(posedge core_clk) disable iff (!rstn)
        q.st == ST_IDLE && q.en && q.tx_pend && !q.locked && !reg_wr |=> q.st == ST_TX_BIT && line_oe)
        else $error("start bit not driven low");

    a_nack_driven: assert property (@(posedge core_clk) disable iff (!rstn)
        q.st == ST_RX_SIG && etu.mid_tick && ^q.rx_shift && !q.prot && !q.neg_ack_disable && !reg_wr
        |=> line_oe [*2])
        else $error("parity error not answered");

    a_nack_suppressed: assert property (@(posedge core_clk) disable iff (!rstn)
        q.st == ST_RX_SIG && etu.mid_tick && (q.neg_ack_disable || q.prot) |=> !line_oe && q.st == ST_IDLE)
        else $error("acknowledge driven while suppressed");

    a_retry_counts: assert property (@(posedge core_clk) disable iff (!rstn)
        tx_finish && q.nack_seen && q.tries != q.retry && !reg_wr
        |=> q.tries == $past(q.tries) + 3'h1 && q.tx_pend && !q.locked)
        else $error("retry not counted");

    a_error_locks: assert property (@(posedge core_clk) disable iff (!rstn)
        tx_finish && q.nack_seen && q.tries == q.retry && !reg_wr
        |=> q.locked && q.irq_stat[IRQ_TX_ERR] && (irq == q.irq_mask[IRQ_TX_ERR] || irq))
        else $error("transmit error not flagged");

    a_locked_silent: assert property (@(posedge core_clk) disable iff (!rstn)
        q.locked && q.st == ST_IDLE |-> ##1 q.st != ST_TX_BIT)
        else $error("transmitter left lock without flush");

    a_guard_length: assert property (@(posedge core_clk) disable iff (!rstn)
        q.st == ST_TX_NACK && etu.etu_tick && !q.prot && q.guard != GUARD_SINGLE && !reg_wr
        |=> q.st == ST_TX_GRD && q.gcnt == {1'b0, $past(q.guard)} + 9'h001)
        else $error("guard count wrong");

    a_single_guard: assert property (@(posedge core_clk) disable iff (!rstn)
        q.st == ST_TX_NACK && etu.etu_tick && !q.prot && q.guard == GUARD_SINGLE |-> tx_finish)
        else $error("single guard unit not honoured");

    a_lock_holds: assert property (@(posedge core_clk) disable iff (!rstn)
        q.locked && !(reg_wr && reg_addr == ADDR_FLUSH && reg_wdata[FLUSH_BIT]) |=> q.locked)
        else $error("lock released without flush");

    a_t1_no_refusal: assert property (@(posedge core_clk) disable iff (!rstn)
        q.st == ST_TX_NACK && q.prot && !q.nack_seen |=> !q.nack_seen)
        else $error("refusal taken under T=1");

    c_retry_taken: cover property (@(posedge core_clk) disable iff (!rstn)
        tx_finish && q.nack_seen && q.tries != q.retry);
    c_error_lock: cover property (@(posedge core_clk) disable iff (!rstn)
        $rose(q.locked));
    c_nack_sent: cover property (@(posedge core_clk) disable iff (!rstn)
        q.st == ST_RX_NACK && line_oe);
    c_char_sent: cover property (@(posedge core_clk) disable iff (!rstn)
        tx_finish && !q.nack_seen);
    c_char_received: cover property (@(posedge core_clk) disable iff (!rstn)
        q.st == ST_RX_SIG && etu.mid_tick);
endmodule
`default_nettype wire

// ==== src/scuc_etu_if.sv ====
// Interface between the control logic and its elementary time unit timer.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface scuc_etu_if;
    logic restart;
    logic etu_tick;
    logic mid_tick;

    modport timer (input restart, output etu_tick, output mid_tick);
    modport ctrl  (output restart, input etu_tick, input mid_tick);
endinterface
`default_nettype wire

// ==== src/scuc_etu_timer.sv ====
// Elementary time unit timer: one-cycle pulses at the middle and the end of each unit.
// Assumes restart is raised in the cycle the first unit of a character begins.
`timescale 1ns/1ps
`default_nettype none
module scuc_etu_timer
    import scuc_pkg::*;
#(
    parameter int ETU = ETU_CYCLES
) (
    // Clock and reset
    input  wire logic  core_clk,
    input  wire logic  rstn,
    // Tick port
    scuc_etu_if.timer  etu
);
    localparam logic [ETU_CNT_W-1:0] END_CNT = ETU_CNT_W'(ETU - 1);
    localparam logic [ETU_CNT_W-1:0] MID_CNT = ETU_CNT_W'(ETU / 2 - 1);

    scuc_timer_t q;
    scuc_timer_t d;

    always_comb begin
        d = q;
        if (etu.restart || q.cnt == END_CNT) begin
            d.cnt = '0;
        end else begin
            d.cnt = q.cnt + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Ticks depend on the count alone, so restart never loops back through the caller's decode.
    assign etu.etu_tick = q.cnt == END_CNT;
    assign etu.mid_tick = q.cnt == MID_CNT;
endmodule
`default_nettype wire

// ==== src/scuc_pkg.sv ====
// Constants, register map and state types of the smart card serial control block.
// Assumes a 40 MHz core clock and a card line sampled synchronously to it.
package scuc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [31:0] ADDR_HALF_DUPLEX = 32'h4000_8040;
    localparam logic [31:0] ADDR_CTRL        = 32'h4000_8048;
    localparam logic [31:0] ADDR_LINE_STAT   = 32'h4000_80e8;
    localparam logic [31:0] ADDR_FLUSH       = 32'h4000_80ec;
    localparam logic [31:0] ADDR_TX_DATA     = 32'h4000_80f0;
    localparam logic [31:0] ADDR_RX_DATA     = 32'h4000_80f4;
    localparam logic [31:0] ADDR_IRQ_STAT    = 32'h4000_80f8;
    localparam logic [31:0] ADDR_IRQ_MASK    = 32'h4000_80fc;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_NACK_BIT  = 1;
    localparam int CTRL_PROT_BIT  = 2;
    localparam int CTRL_RETRY_LSB = 5;
    localparam int CTRL_GUARD_LSB = 8;
    localparam int FLUSH_BIT      = 0;
    localparam int IRQ_TX_DONE    = 0;
    localparam int IRQ_TX_ERR     = 1;
    localparam int IRQ_RX_DONE    = 2;
    localparam int IRQ_RX_PERR    = 3;
    localparam int IRQ_W          = 4;

    localparam logic       CTRL_FLAG_RST  = 1'b0;
    localparam logic [2:0] RETRY_RST      = 3'h0;
    localparam logic [7:0] GUARD_RST      = 8'h00;
    localparam logic [7:0] GUARD_SINGLE   = 8'hff;
    localparam logic [3:0] LAST_BIT       = 4'h9;
    localparam logic [8:0] GUARD_NOMINAL  = 9'h001;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int ETU_CYCLES = 372;
    localparam int ETU_CNT_W  = 11;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_TX_BIT  = 3'b001,
        ST_TX_NACK = 3'b010,
        ST_TX_GRD  = 3'b011,
        ST_RX_BIT  = 3'b100,
        ST_RX_SIG  = 3'b101,
        ST_RX_NACK = 3'b110
    } scuc_state_t;

    typedef struct packed {
        scuc_state_t        st;
        logic               en;
        logic               neg_ack_disable;
        logic               prot;
        logic [2:0]         retry;
        logic [7:0]         guard;
        logic               half_duplex_enable;
        logic [7:0]         tx_hold;
        logic               tx_pend;
        logic               locked;
        logic [9:0]         shift;
        logic [3:0]         bitn;
        logic [8:0]         gcnt;
        logic [2:0]         tries;
        logic               nack_seen;
        logic [8:0]         rx_shift;
        logic [7:0]         rx_data;
        logic               drive;
        logic [IRQ_W-1:0]   irq_stat;
        logic [IRQ_W-1:0]   irq_mask;
        logic [31:0]        rdata;
    } scuc_regs_t;

    typedef struct packed {
        logic [ETU_CNT_W-1:0] cnt;
    } scuc_timer_t;

endpackage

// ==== testbench/scuc_card_model.sv ====
// Behavioural smart card on the open-drain line: receives, refuses and sends characters.
// Assumes the bench resolves the line as a pulled-up wired AND of both pull-downs.
`timescale 1ns/1ps
`default_nettype none
module scuc_card_model #(
    parameter int ETU = 8
) (
    // Clock
    input  wire logic core_clk,
    // Card line
    input  wire logic line,
    output logic      pull_low
);
    int         refuse_left = 0;
    int         rx_count    = 0;
    logic [7:0] rx_byte     = 8'h00;
    logic       sending     = 1'b0;
    logic [8:0] sh;

    initial pull_low = 1'b0;

    // The refusal pulse starts a quarter unit before the sender's sample point at 10.5 units and ends 1.25 units after it.
    always begin
        @(posedge core_clk);
        if (!line && !sending) begin
            repeat (ETU / 2) @(posedge core_clk);
            for (int i = 0; i < 9; i++) begin
                repeat (ETU) @(posedge core_clk);
                sh[i] = line;
            end
            rx_byte = sh[7:0];
            rx_count++;
            if (refuse_left > 0) begin
                refuse_left--;
                repeat (ETU * 3 / 4) @(posedge core_clk);
                pull_low <= 1'b1;
                repeat (ETU * 3 / 2) @(posedge core_clk);
                pull_low <= 1'b0;
            end
            while (!line) @(posedge core_clk);
        end
    end

    // Sends start, data LSB first and parity, then looks for a refusal at 11 units.
    task automatic send(input logic [7:0] d, input logic bad, output logic nacked);
        logic [9:0] fr;
        fr = {^d ^ bad, d, 1'b0};
        sending = 1'b1;
        for (int i = 0; i < 10; i++) begin
            pull_low <= ~fr[i];
            repeat (ETU) @(posedge core_clk);
        end
        pull_low <= 1'b0;
        repeat (ETU) @(posedge core_clk);
        nacked = !line;
        repeat (ETU) @(posedge core_clk);
        sending = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== testbench/smart_card_uart_control_test.sv ====
// Self-checking bench of the smart card control block with a card model on its line.
// Assumes the block's register map and a shortened unit of 8 clock cycles.
`timescale 1ns/1ps
`default_nettype none
module smart_card_uart_control_test
    import scuc_pkg::*;
;
    localparam int UNIT = 8;
    logic        core_clk  = 1'b0;
    logic        rstn      = 1'b0;
    logic [31:0] reg_addr  = 32'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [31:0] reg_rdata;
    logic        line_out;
    logic        line_oe;
    logic        irq;
    logic        card_pull;
    wire logic   line = !(line_oe | card_pull);
    int          errors      = 0;
    int          checks_done = 0;
    logic [31:0] rv;
    logic [31:0] rb;
    logic [7:0]  d;
    logic [7:0]  g;
    logic        pr;
    logic        nk;
    int          n0;
    int          cyc;
    int          r;

    scuc_ctrl #(.ETU(UNIT)) scuc_ctrl_inst (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .line_in(line), .line_out(line_out), .line_oe(line_oe), .irq(irq));
    scuc_card_model #(.ETU(UNIT)) scuc_card_model_inst (.core_clk(core_clk), .line(line),
        .pull_low(card_pull));

    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------------
    // Bus, compare and closing tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks_done=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    function automatic logic [31:0] ctrl_val(input logic en, nd, p, input logic [2:0] rt, input logic [7:0] eg);
        return {16'h0000, eg, rt, 2'b00, p, nd, en};
    endfunction

    // Whole character length in units: ten bits, the refusal window and the guard.
    function automatic int tx_units(input logic p, input logic [7:0] eg);
        return p ? 12 : (eg == 8'hff ? 11 : 12 + int'(eg));
    endfunction

    task automatic send_wait(input logic [7:0] v, output int c);
        wr(ADDR_TX_DATA, {24'h0, v});
        c = 0;
        while (irq !== 1'b1 && c < 400 * UNIT) begin
            @(posedge core_clk);
            c++;
        end
        chk("tx irq", {31'h0, irq}, 32'h1);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(69));
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        rd(ADDR_CTRL, rv);
        chk("ctrl reset", rv, 32'h0);
        chk("line idle", {31'h0, line_oe}, 32'h0);
        wr(ADDR_HALF_DUPLEX, 32'h0);
        rd(ADDR_HALF_DUPLEX, rv);
        chk("half duplex", rv, 32'h0);
        rd(32'h4000_8100, rv);
        chk("unmapped", rv, 32'h0);
        repeat (4) begin
            rv = {16'h0000, 16'($urandom)};
            wr(ADDR_CTRL, rv);
            rd(ADDR_CTRL, rb);
            chk("ctrl readback", rb, rv & 32'h0000_ffe7);
        end
        wr(ADDR_CTRL, 32'h0);
        n0 = scuc_card_model_inst.rx_count;
        wr(ADDR_TX_DATA, 32'h5a);
        repeat (20 * UNIT) @(posedge core_clk);
        chk("disabled send", 32'(scuc_card_model_inst.rx_count - n0), 32'h0);
        wr(ADDR_FLUSH, 32'h1);
        wr(ADDR_IRQ_MASK, 32'h3);
        for (int k = 0; k < 6; k++) begin
            g  = (k == 4) ? 8'hff : 8'($urandom_range(0, 4));
            pr = (k == 5);
            d  = 8'($urandom);
            wr(ADDR_CTRL, ctrl_val(1'b1, 1'b0, pr, 3'h0, g));
            send_wait(d, cyc);
            chk("card byte", {24'h0, scuc_card_model_inst.rx_byte}, {24'h0, d});
            r = tx_units(pr, g) * UNIT;
            chk("char time", 32'(cyc >= r - 2 && cyc <= r + 4), 32'h1);
            wr(ADDR_IRQ_STAT, 32'hf);
        end
        // Retries: success on the last try, lock-up, and a refusal ignored under T=1.
        for (int k = 0; k < 3; k++) begin
            r  = $urandom_range(0, 2);
            pr = (k == 2);
            scuc_card_model_inst.refuse_left = (k == 0) ? r : ((k == 1) ? r + 1 : 1);
            n0 = scuc_card_model_inst.rx_count;
            wr(ADDR_CTRL, ctrl_val(1'b1, 1'b0, pr, 3'(r), 8'h00));
            send_wait(8'($urandom), cyc);
            rd(ADDR_IRQ_STAT, rv);
            chk("tx outcome", rv & 32'h3, (k == 1) ? 32'h2 : 32'h1);
            chk("attempts", 32'(scuc_card_model_inst.rx_count - n0), pr ? 32'h1 : 32'(r + 1));
            if (k == 1) begin
                rd(ADDR_LINE_STAT, rv);
                chk("locked", rv & 32'h1, 32'h1);
                repeat (30 * UNIT) @(posedge core_clk);
                chk("silent while locked", 32'(scuc_card_model_inst.rx_count - n0), 32'(r + 1));
                wr(ADDR_FLUSH, 32'h1);
                rd(ADDR_LINE_STAT, rv);
                chk("unlocked", rv & 32'h9, 32'h0);
            end
            wr(ADDR_IRQ_STAT, 32'hf);
        end
        wr(ADDR_IRQ_MASK, 32'h0);
        for (int k = 0; k < 4; k++) begin
            d = 8'($urandom);
            wr(ADDR_CTRL, ctrl_val(1'b1, k == 1, k == 2, 3'h0, 8'h00));
            scuc_card_model_inst.send(d, k != 3, nk);
            chk("refusal sent", {31'h0, nk}, {31'h0, k == 0});
            rd(ADDR_RX_DATA, rv);
            chk("rx data", rv, {24'h0, d});
            rd(ADDR_IRQ_STAT, rv);
            chk("rx status", rv & 32'hc, (k == 3) ? 32'h4 : 32'hc);
            chk("irq masked", {31'h0, irq}, 32'h0);
            wr(ADDR_IRQ_MASK, 32'h4);
            #1 chk("irq raised", {31'h0, irq}, 32'h1);
            wr(ADDR_IRQ_STAT, 32'hc);
            #1 chk("irq cleared", {31'h0, irq}, 32'h0);
            wr(ADDR_IRQ_MASK, 32'h0);
        end
        // A second reset in mid-run must clear every control field again.
        wr(ADDR_CTRL, 32'h0000_0027);
        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        rd(ADDR_CTRL, rv);
        chk("ctrl after reset", rv, 32'h0);
        chk("line out low", {31'h0, line_out}, 32'h0);
        complete_run();
    end

    // The whole sequence needs well under a fifth of this span.
    initial begin
        repeat (90000) @(posedge core_clk);
        errors++;
        complete_run();
    end
endmodule
`default_nettype wire
